/* mbt_turnaround.sv */
// muxed address/data bus sequencer with turnaround and bus grant
`timescale 1ns/1ps
//
// Overview of operation
// - read drives address then floats bus; write drives address then data
// - after read, grant or idle the bus is floated; next cycle drives address
// - write ends driving data, then goes straight to address or float
// - no external cycle pending keeps the shared bus floated
// - two idle bus clocks at least between one read and the next
// - data phase indicator asserts only after bus floated; memory drives after
// - a bus request wins right after the current cycle completes
// - bus request sampled only at bus clock rising edges
// - while granted, all control outputs float except clock and grant
// - requester drops request when done; grant drops and control resumes
// - grant rises on bus clock rise, falls on bus clock fall
// - controls driven to idle levels before floating for a grant
// - read to next cycle: half clock plain, clock and half via request
// - data phase indicator negated in address phase, writes and idle
// - address latched as latch strobe falls; read floats bus there
module mbt_turnaround (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic core_ce,
    input wire mbt_pkg::mbt_req_s cyc_req,
    output mbt_pkg::mbt_rsp_s cyc_rsp,
    input wire logic [mbt_pkg::AD_W-1:0] ad_in,
    output logic [mbt_pkg::AD_W-1:0] ad_out,
    output logic ad_oe_n,
    output mbt_pkg::mbt_ctrl_s bus_ctrl,
    output logic ctrl_oe_n,
    input wire logic mem_ack,
    input wire logic ext_bus_request,
    output logic ext_bus_grant,
    output logic cpu_bus_clock
);
    import mbt_pkg::*;

    mbt_state_s q;
    mbt_state_s d;
    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_sync;
    logic rise;
    logic go;
    logic req_hi;
    logic ack_hi;

    // ****************************************
    // pin synchronisers
    // ****************************************
    assign pins_raw = {mem_ack, ext_bus_request};

    mbt_sync u_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .core_ce(core_ce),
        .pin_in(pins_raw),
        .pin_out(pins_sync)
    );

    assign req_hi = pins_sync[SYNC_REQ];
    assign ack_hi = pins_sync[SYNC_ACK];
    // bus clock is core clock halved; this cycle ends with its rising edge
    assign rise = ~q.bclk;

    // ****************************************
    // sequencer
    // ****************************************
    always_comb begin
        d = q;
        go = 1'b0;
        d.bclk = ~q.bclk;
        d.rsp.done = 1'b0;
        unique case (q.st)
            ST_IDLE: begin
                go = rise;
            end
            ST_ADDR: begin
                if (rise) begin
                    d.ctrl.ale = 1'b0;
                    if (q.wr) begin
                        d.st = ST_WDATA;
                        d.ad_out = cyc_req.wdata;
                        d.ctrl.wr_n = 1'b0;
                    end else begin
                        d.st = ST_RDATA;
                        d.ad_oe_n = 1'b1;
                        d.ctrl.rd_n = 1'b0;
                    end
                end
            end
            ST_RDATA: begin
                // indicator waits half a clock behind the float
                if (!rise) begin
                    d.ctrl.data_phase_indicator_n = 1'b0;
                end else if (ack_hi) begin
                    d.st = ST_RECOV;
                    d.rsp.done = 1'b1;
                    d.rsp.rdata = ad_in;
                    d.ctrl = CTRL_IDLE;
                    d.cnt = RD_GAP_BCLK - 2'h1;
                end
            end
            ST_WDATA: begin
                if (rise && ack_hi) begin
                    d.st = ST_WHOLD;
                    d.rsp.done = 1'b1;
                    d.ctrl.wr_n = 1'b1;
                end
            end
            ST_WHOLD: begin
                go = rise;
            end
            ST_RECOV: begin
                // writes need no read gap, a grant already outlasts it
                if (rise) begin
                    if (q.cnt == 2'h0 || req_hi ||
                        (cyc_req.valid && cyc_req.write)) begin
                        go = 1'b1;
                    end else begin
                        d.cnt = q.cnt - 2'h1;
                    end
                end
            end
            ST_GPREP: begin
                if (rise) begin
                    d.st = ST_GRANT;
                    d.grant = 1'b1;
                    d.ctrl_oe_n = 1'b1;
                end
            end
            ST_GRANT: begin
                if (rise && !req_hi) begin
                    d.st = ST_GDROP;
                end
            end
            ST_GDROP: begin
                if (!rise) begin
                    d.st = ST_GRESUME;
                    d.grant = 1'b0;
                    d.ctrl_oe_n = 1'b0;
                end
            end
            ST_GRESUME: begin
                go = rise;
            end
            default: begin
                d = STATE_RST;
            end
        endcase
        if (go) begin
            d.ctrl = CTRL_IDLE;
            if (req_hi) begin
                d.st = ST_GPREP;
                d.ad_oe_n = 1'b1;
            end else if (cyc_req.valid) begin
                d.st = ST_ADDR;
                d.wr = cyc_req.write;
                d.ad_out = cyc_req.addr;
                d.ad_oe_n = 1'b0;
                d.ctrl.ale = 1'b1;
            end else begin
                d.st = ST_IDLE;
                d.ad_oe_n = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            q <= STATE_RST;
        end else if (core_ce) begin
            q <= d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign cyc_rsp = q.rsp;
    assign ad_out = q.ad_out;
    assign ad_oe_n = q.ad_oe_n;
    assign bus_ctrl = q.ctrl;
    assign ctrl_oe_n = q.ctrl_oe_n;
    assign ext_bus_grant = q.grant;
    assign cpu_bus_clock = q.bclk;

    // ****************************************
    // assertions
    // ****************************************
    AST_READ_FLOAT: assert property (@(posedge core_clk) disable iff (sys_rst)
        !bus_ctrl.rd_n |-> ad_oe_n && !bus_ctrl.ale)
        else $error("bus driven during read data phase");

    AST_WRITE_DRIVE: assert property (@(posedge core_clk) disable iff (sys_rst)
        $fell(bus_ctrl.wr_n) |-> !ad_oe_n && $past(bus_ctrl.ale))
        else $error("write data not driven after address");

    AST_WRITE_END_DATA: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        $rose(bus_ctrl.wr_n) |-> !ad_oe_n ##1 !ad_oe_n)
        else $error("write ended without data driven");

    AST_IDLE_FLOAT: assert property (@(posedge core_clk) disable iff (sys_rst)
        q.st == ST_IDLE |-> ad_oe_n && bus_ctrl == CTRL_IDLE)
        else $error("bus driven while idle");

    AST_DPI_AFTER_FLOAT: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        $fell(bus_ctrl.data_phase_indicator_n) |->
            $past(ad_oe_n) && ad_oe_n && !bus_ctrl.rd_n)
        else $error("data phase indicated before bus floated");

    AST_DPI_NEGATED: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (bus_ctrl.ale || !bus_ctrl.wr_n || q.st == ST_IDLE) |->
            bus_ctrl.data_phase_indicator_n)
        else $error("data phase indicated outside read data phase");

    AST_READ_GAP: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(bus_ctrl.rd_n) |=> bus_ctrl.rd_n [*5])
        else $error("reads closer than two idle bus clocks");

    AST_GRANT_RISE: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        $rose(ext_bus_grant) |-> $rose(cpu_bus_clock) && ctrl_oe_n)
        else $error("grant not raised on bus clock rise");

    AST_GRANT_FALL: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        $fell(ext_bus_grant) |-> $fell(cpu_bus_clock))
        else $error("grant not dropped on bus clock fall");

    AST_GRANT_FLOAT: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        ext_bus_grant |-> ctrl_oe_n && ad_oe_n && q.st != ST_ADDR)
        else $error("bus or control driven while granted");

    AST_IDLE_BEFORE_FLOAT: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        $rose(ctrl_oe_n) |-> $past(bus_ctrl) == CTRL_IDLE
            && $past(ctrl_oe_n, 2) == 1'b0)
        else $error("control floated before idle levels driven");

    AST_GRANT_RELEASE: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        (ext_bus_grant && !req_hi && !cpu_bus_clock) |=>
            ##[1:2] !ext_bus_grant)
        else $error("grant held after request dropped");

endmodule

/* mbt_pkg.sv */
// shared constants and types for the muxed bus turnaround block
package mbt_pkg;

    // ****************************************
    // widths and counts
    // ****************************************
    localparam int AD_W = 32;
    localparam int SYNC_W = 2;
    localparam int SYNC_REQ = 0;
    localparam int SYNC_ACK = 1;
    // idle bus clocks that must separate two reads
    localparam logic [1:0] RD_GAP_BCLK = 2'h2;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_RDATA,
        ST_WDATA,
        ST_WHOLD,
        ST_RECOV,
        ST_GPREP,
        ST_GRANT,
        ST_GDROP,
        ST_GRESUME
    } mbt_state_e;

    typedef struct packed {
        logic ale;
        logic rd_n;
        logic wr_n;
        logic data_phase_indicator_n;
    } mbt_ctrl_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [AD_W-1:0] addr;
        logic [AD_W-1:0] wdata;
    } mbt_req_s;

    typedef struct packed {
        logic done;
        logic [AD_W-1:0] rdata;
    } mbt_rsp_s;

    typedef struct packed {
        mbt_state_e st;
        logic [1:0] cnt;
        logic wr;
        logic bclk;
        logic grant;
        mbt_ctrl_s ctrl;
        logic ctrl_oe_n;
        logic [AD_W-1:0] ad_out;
        logic ad_oe_n;
        mbt_rsp_s rsp;
    } mbt_state_s;

    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] out;
    } mbt_sync_s;

    // ****************************************
    // reset values
    // ****************************************
    localparam mbt_ctrl_s CTRL_IDLE = '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1,
        data_phase_indicator_n: 1'b1};

    localparam mbt_state_s STATE_RST = '{st: ST_IDLE, cnt: 2'h0, wr: 1'b0,
        bclk: 1'b0, grant: 1'b0, ctrl: CTRL_IDLE, ctrl_oe_n: 1'b0,
        ad_out: '0, ad_oe_n: 1'b1, rsp: '0};

    localparam mbt_sync_s SYNC_RST = '{s1: '0, s2: '0, s3: '0, out: '0};

endpackage

/* mbt_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module mbt_sync (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic core_ce,
    input wire logic [mbt_pkg::SYNC_W-1:0] pin_in,
    output logic [mbt_pkg::SYNC_W-1:0] pin_out
);
    import mbt_pkg::*;

    mbt_sync_s q;
    mbt_sync_s d;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        d = q;
        d.s1 = pin_in;
        d.s2 = q.s1;
        d.s3 = q.s2;
        // stage one feeds only stage two, so metastability stays contained
        for (int i = 0; i < SYNC_W; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.out[i] = q.s3[i];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            q <= SYNC_RST;
        end else if (core_ce) begin
            q <= d;
        end
    end

    assign pin_out = q.out;

endmodule

/* mbt_mem_model.sv */
// memory, transceiver and turnaround requester model for the muxed bus
`timescale 1ns/1ps
module mbt_mem_model (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire mbt_pkg::mbt_ctrl_s bus_ctrl,
    input wire logic ctrl_oe_n,
    input wire logic [mbt_pkg::AD_W-1:0] ad_out,
    input wire logic ad_oe_n,
    input wire logic [2:0] lat,
    input wire logic turn_en,
    input wire logic cpu_bus_clock,
    input wire logic clk_mode,
    output logic [mbt_pkg::AD_W-1:0] ad_in,
    output logic mem_ack,
    output logic turn_req,
    output logic clash
);
    import mbt_pkg::*;
    mbt_ctrl_s pin;
    logic [AD_W-1:0] mem [16];
    logic [AD_W-1:0] addr_q;
    logic [AD_W-1:0] last_q;
    logic [2:0] wait_q;
    logic [3:0] hold_q;
    logic mem_drv;
    logic rd_clk_q;
    logic quiet;
    // floated controls settle at their pull levels
    assign pin = ctrl_oe_n ? CTRL_IDLE : bus_ctrl;
    assign quiet = pin.rd_n && pin.wr_n;
    // drive after the indicator, let go the moment it negates
    // clock mode waits for the first bus clock rise after the read strobe
    assign mem_drv = !pin.rd_n &&
        (clk_mode ? rd_clk_q : !pin.data_phase_indicator_n);
    assign clash = mem_drv && !ad_oe_n;
    // a floating bus toggles, so a stale value can never pass
    assign ad_in = !ad_oe_n ? ad_out : mem_drv ? mem[addr_q[5:2]] : ~last_q;
    // buffered read strobe stretched into a request
    // only the slow half of the map asks for extra turnaround
    assign turn_req = turn_en &&
        ((!pin.rd_n && addr_q[5]) || hold_q != 4'h0);
    always @(posedge core_clk) begin
        last_q <= ad_in;
        if (pin.ale) begin
            addr_q <= ad_in;
        end
        if (!pin.wr_n) begin
            mem[addr_q[5:2]] <= ad_in;
        end
        rd_clk_q <= !pin.rd_n && (rd_clk_q || !cpu_bus_clock);
        if (!pin.rd_n && addr_q[5]) begin
            hold_q <= 4'h6;
        end else if (hold_q != 4'h0) begin
            hold_q <= hold_q - 4'h1;
        end
        wait_q <= quiet ? 3'h0 : wait_q + 3'(wait_q < lat);
        mem_ack <= !quiet && wait_q >= lat;
        if (sys_rst) begin
            wait_q <= 3'h0;
            hold_q <= 4'h0;
            rd_clk_q <= 1'b0;
            mem_ack <= 1'b0;
        end
    end
endmodule

/* mbt_turnaround_bench.sv */
// self-checking bench for the muxed bus turnaround sequencer
`timescale 1ns/1ps
module mbt_turnaround_bench;
    import mbt_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    mbt_req_s cyc_req = '0;
    mbt_rsp_s cyc_rsp;
    logic [AD_W-1:0] ad_in;
    logic [AD_W-1:0] ad_out;
    logic ad_oe_n, ctrl_oe_n, mem_ack, ext_bus_grant, cpu_bus_clock;
    logic turn_req, clash, bench_req = 1'b0, turn_en = 1'b0;
    logic clk_mode = 1'b0;
    logic [2:0] lat = 3'h0;
    mbt_ctrl_s bus_ctrl;
    mbt_ctrl_s p;
    logic [AD_W-1:0] shadow [16];
    int bad_count = 0;
    int tests_run = 0;
    int gap = 0;
    int lowcnt = 0;
    logic rd_last, rd_prev, ale_prev, gnt_prev, coe_prev;
    always #2 core_clk = ~core_clk;
    mbt_turnaround DUT (.core_clk(core_clk), .sys_rst(sys_rst),
        .core_ce(1'b1), .cyc_req(cyc_req), .cyc_rsp(cyc_rsp),
        .ad_in(ad_in), .ad_out(ad_out), .ad_oe_n(ad_oe_n),
        .bus_ctrl(bus_ctrl), .ctrl_oe_n(ctrl_oe_n), .mem_ack(mem_ack),
        .ext_bus_request(bench_req | turn_req),
        .ext_bus_grant(ext_bus_grant), .cpu_bus_clock(cpu_bus_clock));
    mbt_mem_model mem_u (.core_clk(core_clk), .sys_rst(sys_rst),
        .bus_ctrl(bus_ctrl), .ctrl_oe_n(ctrl_oe_n), .ad_out(ad_out),
        .ad_oe_n(ad_oe_n), .lat(lat), .turn_en(turn_en),
        .cpu_bus_clock(cpu_bus_clock), .clk_mode(clk_mode), .ad_in(ad_in),
        .mem_ack(mem_ack), .turn_req(turn_req), .clash(clash));
    // ********
    // checking
    // ********
    function automatic int min_gap(logic nxt_wr, logic turn);
        return turn ? 3 : nxt_wr ? 1 : 2 * int'(RD_GAP_BCLK);
    endfunction
    task automatic check_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_word(input logic [AD_W-1:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // pins watched mid-cycle, where every update has landed
    always @(negedge core_clk) begin
        p = ctrl_oe_n ? CTRL_IDLE : bus_ctrl;
        if (sys_rst) begin
            gap = 0;
            rd_last = 1'b0;
        end else begin
            check_bit(clash, 1'b0);
            if (p.data_phase_indicator_n === 1'b0) begin
                check_bit(ad_oe_n, 1'b1);
                check_bit(p.rd_n, 1'b0);
            end
            if (p.ale === 1'b1) begin
                check_word(ad_out, cyc_req.addr);
                check_bit(ad_oe_n, 1'b0);
            end
            if (p.wr_n === 1'b0) begin
                check_word(ad_out, cyc_req.wdata);
                check_bit(ad_oe_n, 1'b0);
            end
            if (ext_bus_grant === 1'b1) begin
                check_bit(ctrl_oe_n, 1'b1);
                check_bit(ad_oe_n, 1'b1);
            end
            if (p.ale && !ale_prev && rd_last) begin
                check_bit(gap >= min_gap(cyc_req.write, turn_en), 1'b1);
            end
            if (ext_bus_grant && !gnt_prev) begin
                check_bit(cpu_bus_clock, 1'b1);
                if (turn_en) check_bit(gap <= 4, 1'b1);
            end
            if (!ext_bus_grant && gnt_prev) begin
                check_bit(cpu_bus_clock, 1'b0);
                check_bit(lowcnt <= 9, 1'b1);
            end
            if (ctrl_oe_n && !coe_prev) check_bit(bus_ctrl === CTRL_IDLE, 1'b1);
            lowcnt = ext_bus_grant && !bench_req && !turn_req ? lowcnt + 1 : 0;
            gap = !rd_prev && p.rd_n ? 1 : gap + 1;
            rd_last = !p.wr_n ? 1'b0 : !p.rd_n ? 1'b1 : rd_last;
        end
        rd_prev = p.rd_n;
        ale_prev = p.ale;
        gnt_prev = ext_bus_grant;
        coe_prev = ctrl_oe_n;
    end
    // ********
    // stimulus
    // ********
    task automatic do_cyc(input logic w, input logic [3:0] idx);
        int n;
        logic [AD_W-1:0] d;
        n = 0;
        d = $urandom;
        @(posedge core_clk);
        cyc_req <= '{valid: 1'b1, write: w, addr: {26'h0, idx, 2'h0}, wdata: d};
        lat <= 3'($urandom_range(4));
        clk_mode <= 1'($urandom);
        do begin
            @(negedge core_clk);
            n++;
        end while (cyc_rsp.done !== 1'b1 && n < 300);
        check_bit(cyc_rsp.done, 1'b1);
        if (w) shadow[idx] = d;
        else check_word(cyc_rsp.rdata, shadow[idx]);
        @(posedge core_clk);
        cyc_req.valid <= 1'b0;
    endtask
    initial begin
        void'($urandom(32'h17d6));
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 16; i++) do_cyc(1'b1, 4'(i));
        $display("test fill done");
        for (int i = 0; i < 40; i++) do_cyc(1'($urandom), 4'($urandom));
        $display("test random done");
        turn_en <= 1'b1;
        for (int i = 0; i < 12; i++) do_cyc(1'($urandom), 4'($urandom));
        turn_en <= 1'b0;
        $display("test turnaround done");
        fork
            begin
                @(posedge core_clk);
                bench_req <= 1'b1;
                repeat (12) @(posedge core_clk);
                check_bit(ext_bus_grant, 1'b1);
                repeat (12) @(posedge core_clk);
                bench_req <= 1'b0;
            end
            begin
                repeat (8) @(posedge core_clk);
                do_cyc(1'b0, 4'h3);
            end
        join
        $display("test grant done");
        repeat (12) @(negedge core_clk);
        check_bit(ad_oe_n, 1'b1);
        $display("test idle done");
        stop_test;
    end
    initial begin
        #100000;
        bad_count++;
        stop_test;
    end
endmodule
